/* File: mct_defines.svh */
// Constants for the match/capture counter-timer: register offsets, field
// positions, reset values. Assumes an AXI4-Lite slave with 32-bit words.
//
// Overview of operation
// - Counter builds as 32-bit or 16-bit width
// - Prescaler of counter width divides counting clock
// - Timer mode or external-edge counter mode selectable
// - Four match registers compared with running count
// - Match may interrupt while counter keeps running
// - Match may stop the counter
// - Match may reset the counter to zero
// - Match outputs go low, high, toggle, or hold
// - Capture edge loads count into capture register
// - Capture event may raise an interrupt
// - Capture edge may clear counter and prescaler
// - Clear edge and capture edge chosen independently
`ifndef MCT_DEFINES_SVH
`define MCT_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define MCT_ADDR_CTRL     8'h00
`define MCT_ADDR_COUNT    8'h04
`define MCT_ADDR_PRE_LIM  8'h08
`define MCT_ADDR_PRE_CNT  8'h0c
`define MCT_ADDR_MCTL     8'h10
`define MCT_ADDR_CAPCTL   8'h14
`define MCT_ADDR_CAPVAL   8'h18
`define MCT_ADDR_STATUS   8'h1c
`define MCT_ADDR_MASK     8'h20
`define MCT_ADDR_EXTOUT   8'h24
`define MCT_ADDR_MATCH0   8'h30
`define MCT_ADDR_MATCH1   8'h34

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define MCT_CTRL_EN       0
`define MCT_CTRL_CMODE    1
`define MCT_CTRL_CEDGE_LO 2
`define MCT_CAP_RISE      0
`define MCT_CAP_FALL      1
`define MCT_CLR_RISE      2
`define MCT_CLR_FALL      3
`define MCT_STAT_CAP      4
`define MCT_NUM_MATCH     4

// ----------------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------------
`define MCT_CTRL_RST      32'h0000_0000
`define MCT_RESP_OKAY     2'h0
`define MCT_RESP_SLVERR   2'h2

`endif

/* File: mct_pkg.sv */
// Types shared by the counter-timer files.
// Assumes the defines header is compiled alongside.
package mct_pkg;
    // Action on each match output pin
    typedef enum logic [1:0] {
        EXT_HOLD   = 2'h0,
        EXT_LOW    = 2'h1,
        EXT_HIGH   = 2'h2,
        EXT_TOGGLE = 2'h3
    } ext_action_type;
endpackage

/* File: mct_edge.sv */
// Edge detector for the external count and capture inputs.
// Assumes inputs are already synchronous to aclk.
module mct_edge (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic sig,
    output logic      rise,
    output logic      fall
);
    logic sig_q;

    // Previous sample; the input is taken as synchronous
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sig_q <= 1'b0;
        end else begin
            sig_q <= sig;
        end
    end

    assign rise = sig & ~sig_q;
    assign fall = ~sig & sig_q;
endmodule

/* File: mct_timer.sv */
// Match/capture counter-timer with AXI4-Lite register access.
// Assumes capture and count inputs synchronous to aclk.
`include "mct_defines.svh"
module mct_timer #(
    parameter int WIDTH = 32
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        cap_in,
    input  wire logic        count_in,
    output logic [3:0]       match_out,
    output logic             irq
);
    localparam int NM = `MCT_NUM_MATCH;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [2:0]       ctrl_q;
    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] pre_lim_q;
    logic [WIDTH-1:0] pre_cnt_q;
    logic [11:0]      mctl_q;     // Per match: irq, reset, stop
    logic [3:0]       capctl_q;
    logic [WIDTH-1:0] capval_q;
    logic [4:0]       status_q;
    logic [4:0]       mask_q;
    logic [7:0]       extctl_q;
    logic [WIDTH-1:0] match_q [NM];
    logic [3:0]       ext_q;
    logic             irq_q;

    logic aw_q, w_q, bvalid_q, rvalid_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [1:0]  bresp_q, rresp_q;
    logic [3:0]  s_axi_wstrb_q;
    logic        awready_q, wready_q, arready_q; // Readies kept in flops

    // ------------------------------------------------------------------
    // Input edges
    // ------------------------------------------------------------------
    wire cap_rise, cap_fall, cnt_rise, cnt_fall;

    mct_edge u_cap (
        .aclk    (aclk),
        .aresetn (aresetn),
        .sig     (cap_in),
        .rise    (cap_rise),
        .fall    (cap_fall)
    );

    mct_edge u_cnt (
        .aclk    (aclk),
        .aresetn (aresetn),
        .sig     (count_in),
        .rise    (cnt_rise),
        .fall    (cnt_fall)
    );

    // Counter mode picks one edge of count_in; timer mode every clock
    wire cnt_edge = ctrl_q[`MCT_CTRL_CEDGE_LO] ? cnt_fall : cnt_rise;
    wire tick_src = ctrl_q[`MCT_CTRL_CMODE] ? cnt_edge : 1'b1;
    wire running  = ctrl_q[`MCT_CTRL_EN];
    wire pre_wrap = running && tick_src && (pre_cnt_q == pre_lim_q);
    wire adv      = pre_wrap;

    // Capture and clear edges are chosen separately
    wire cap_ev = (capctl_q[`MCT_CAP_RISE] & cap_rise) |
                  (capctl_q[`MCT_CAP_FALL] & cap_fall);
    wire clr_ev = (capctl_q[`MCT_CLR_RISE] & cap_rise) |
                  (capctl_q[`MCT_CLR_FALL] & cap_fall);

    // ------------------------------------------------------------------
    // Match compare
    // ------------------------------------------------------------------
    wire [3:0] hit;
    genvar g;
    generate
        for (g = 0; g < NM; g++) begin : g_match
            // Qualified by advance so a held count fires only once
            assign hit[g] = adv && (count_q == match_q[g]);
        end
    endgenerate

    wire [3:0] stop_hit, rst_hit, irq_hit;
    generate
        for (g = 0; g < NM; g++) begin : g_act
            assign stop_hit[g] = hit[g] & mctl_q[3*g];
            assign rst_hit[g]  = hit[g] & mctl_q[3*g+1];
            assign irq_hit[g]  = hit[g] & mctl_q[3*g+2];
        end
    endgenerate

    // Next output level of a pin for its programmed action
    function automatic logic ext_next(input logic cur, input logic [1:0] a);
        case (mct_pkg::ext_action_type'(a))
            mct_pkg::EXT_LOW:    ext_next = 1'b0;
            mct_pkg::EXT_HIGH:   ext_next = 1'b1;
            mct_pkg::EXT_TOGGLE: ext_next = ~cur;
            default:             ext_next = cur;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    wire wr_go = aw_q && w_q && !bvalid_q;
    wire rd_go = s_axi_arvalid && s_axi_arready;
    wire [7:0] wa = awaddr_q;
    wire [31:0] wmask = {{8{s_axi_wstrb_q[3]}}, {8{s_axi_wstrb_q[2]}},
                         {8{s_axi_wstrb_q[1]}}, {8{s_axi_wstrb_q[0]}}};
    wire [31:0] wv = wdata_q & wmask;

    function automatic logic is_match(input logic [7:0] a);
        is_match = (a >= `MCT_ADDR_MATCH0) &&
                   (a < `MCT_ADDR_MATCH0 + 8'h10) && (a[1:0] == 2'h0);
    endfunction

    function automatic logic known(input logic [7:0] a);
        known = is_match(a) || ((a <= `MCT_ADDR_EXTOUT) && a[1:0] == 2'h0);
    endfunction

    wire [1:0] widx = wa[3:2];
    wire [1:0] ridx = s_axi_araddr[3:2];
    wire wr_pre = wr_go && wa == `MCT_ADDR_PRE_CNT;
    wire wr_cnt = wr_go && wa == `MCT_ADDR_COUNT;

    // Read mux; narrow registers sit in the low bits
    logic [31:0] rmux;
    always_comb begin
        rmux = 32'h0000_0000;
        case (s_axi_araddr)
            `MCT_ADDR_CTRL:    rmux[2:0] = ctrl_q;
            `MCT_ADDR_COUNT:   rmux[WIDTH-1:0] = count_q;
            `MCT_ADDR_PRE_LIM: rmux[WIDTH-1:0] = pre_lim_q;
            `MCT_ADDR_PRE_CNT: rmux[WIDTH-1:0] = pre_cnt_q;
            `MCT_ADDR_MCTL:    rmux[11:0] = mctl_q;
            `MCT_ADDR_CAPCTL:  rmux[3:0] = capctl_q;
            `MCT_ADDR_CAPVAL:  rmux[WIDTH-1:0] = capval_q;
            `MCT_ADDR_STATUS:  rmux[4:0] = status_q;
            `MCT_ADDR_MASK:    rmux[4:0] = mask_q;
            `MCT_ADDR_EXTOUT:  rmux[7:0] = extctl_q;
            default: begin
                if (is_match(s_axi_araddr)) begin
                    rmux[WIDTH-1:0] = match_q[ridx];
                end
            end
        endcase
    end

    // ------------------------------------------------------------------
    // AXI4-Lite handshakes; each channel taken independently
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            bvalid_q <= 1'b0;
            rvalid_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            s_axi_wstrb_q <= 4'h0;
            rdata_q <= 32'h0000_0000;
            bresp_q <= 2'h0;
            rresp_q <= 2'h0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            arready_q <= 1'b1;
        end else begin
            if (s_axi_awvalid && !aw_q) begin
                aw_q <= 1'b1;
                awready_q <= 1'b0;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_q) begin
                w_q <= 1'b1;
                wready_q <= 1'b0;
                wdata_q <= s_axi_wdata;
                s_axi_wstrb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
                bvalid_q <= 1'b1;
                bresp_q <= known(wa) ? `MCT_RESP_OKAY : `MCT_RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
            if (rd_go) begin
                rvalid_q <= 1'b1;
                arready_q <= 1'b0;
                rdata_q <= rmux;
                rresp_q <= known(s_axi_araddr) ? `MCT_RESP_OKAY
                                               : `MCT_RESP_SLVERR;
            end else if (rvalid_q && s_axi_rready) begin
                rvalid_q <= 1'b0;
                arready_q <= 1'b1;
            end
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_arready = arready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    wire any_stop = |stop_hit;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= 3'h0;
            pre_lim_q <= '0;
            mctl_q <= 12'h000;
            capctl_q <= 4'h0;
            mask_q <= 5'h00;
            extctl_q <= 8'h00;
        end else begin
            if (wr_go && wa == `MCT_ADDR_CTRL) begin
                ctrl_q <= wv[2:0];
            end
            if (any_stop) begin
                ctrl_q[`MCT_CTRL_EN] <= 1'b0;
            end
            if (wr_go && wa == `MCT_ADDR_PRE_LIM) begin
                pre_lim_q <= wv[WIDTH-1:0];
            end
            if (wr_go && wa == `MCT_ADDR_MCTL) begin
                mctl_q <= wv[11:0];
            end
            if (wr_go && wa == `MCT_ADDR_CAPCTL) begin
                capctl_q <= wv[3:0];
            end
            if (wr_go && wa == `MCT_ADDR_MASK) begin
                mask_q <= wv[4:0];
            end
            if (wr_go && wa == `MCT_ADDR_EXTOUT) begin
                extctl_q <= wv[7:0];
            end
        end
    end

    generate
        for (g = 0; g < NM; g++) begin : g_mreg
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    match_q[g] <= '0;
                end else if (wr_go && is_match(wa) && widx == 2'(g)) begin
                    match_q[g] <= wv[WIDTH-1:0];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Prescaler and counter; capture clear beats everything else
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_cnt_q <= '0;
            count_q <= '0;
        end else begin
            if (clr_ev) begin
                pre_cnt_q <= '0;
                count_q <= '0;
            end else begin
                if (wr_pre) begin
                    pre_cnt_q <= wv[WIDTH-1:0];
                end else if (pre_wrap) begin
                    pre_cnt_q <= '0;
                end else if (running && tick_src) begin
                    pre_cnt_q <= pre_cnt_q + 1'b1;
                end
                if (wr_cnt) begin
                    count_q <= wv[WIDTH-1:0];
                end else if (|rst_hit) begin
                    count_q <= '0;
                end else if (adv && !any_stop) begin
                    count_q <= count_q + 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Capture, status, interrupt and match pins
    // ------------------------------------------------------------------
    wire [4:0] ev = {cap_ev, irq_hit};
    wire [4:0] w1c = (wr_go && wa == `MCT_ADDR_STATUS) ? wv[4:0] : 5'h00;
    wire [4:0] mask_d = (wr_go && wa == `MCT_ADDR_MASK) ? wv[4:0] : mask_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            capval_q <= '0;
            status_q <= 5'h00;
            irq_q <= 1'b0;
        end else begin
            if (cap_ev) begin
                capval_q <= count_q;
            end
            status_q <= (status_q & ~w1c) | ev;
            // Next mask too, so irq never lags a mask write
            irq_q <= |(((status_q & ~w1c) | ev) & mask_d);
        end
    end

    generate
        for (g = 0; g < NM; g++) begin : g_ext
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    ext_q[g] <= 1'b0;
                end else if (hit[g]) begin
                    ext_q[g] <= ext_next(ext_q[g], extctl_q[2*g+1:2*g]);
                end
            end
        end
    endgenerate

    assign match_out = ext_q;
    assign irq = irq_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_stop_halts: assert property (@(posedge aclk) disable iff (!aresetn)
        any_stop && !clr_ev |=> !ctrl_q[`MCT_CTRL_EN])
        else $error("stop on match did not halt");
    a_reset_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        |rst_hit && !clr_ev && !wr_cnt |=> count_q == '0)
        else $error("reset on match did not zero count");
    a_cap_load: assert property (@(posedge aclk) disable iff (!aresetn)
        cap_ev |=> capval_q == $past(count_q))
        else $error("capture value wrong");
    a_clear_both: assert property (@(posedge aclk) disable iff (!aresetn)
        clr_ev |=> count_q == '0 && pre_cnt_q == '0)
        else $error("capture clear failed");
    a_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
        |irq_hit |=> (status_q[3:0] & $past(irq_hit)) == $past(irq_hit))
        else $error("match flag not set");
    a_cap_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        cap_ev |=> status_q[`MCT_STAT_CAP])
        else $error("capture flag not set");
    a_pre_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
        pre_wrap && !clr_ev && !wr_pre |=> pre_cnt_q == '0)
        else $error("prescaler did not wrap");
    a_run_count: assert property (@(posedge aclk) disable iff (!aresetn)
        adv && !clr_ev && !wr_cnt && !(|rst_hit) && !any_stop
        |=> count_q == $past(count_q) + 1'b1)
        else $error("count did not advance");
    a_hold_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        !running && !clr_ev && !wr_cnt |=> $stable(count_q))
        else $error("count moved while stopped");
    a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
        irq_q == |(status_q & mask_q))
        else $error("irq does not follow status and mask");
    c_match: cover property (@(posedge aclk) |hit);
    c_capture: cover property (@(posedge aclk) cap_ev);
    c_clear: cover property (@(posedge aclk) clr_ev);
    c_stop: cover property (@(posedge aclk) any_stop);
endmodule

/* File: mct_far_side.sv */
// Far-side model: the external signal source on the capture and count pins.
// Assumes aclk comes from the bench; lines change just after rising edges.
module mct_far_side (
    input  wire logic aclk,
    output logic      cap_in,
    output logic      count_in
);
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------------
    // Idle levels
    // ------------------------------------------------------------------
    initial begin
        cap_in = 1'b0;
        count_in = 1'b0;
    end

    // Count pulses, two cycles high and three low between pulses
    task automatic pulse_count(input int n);
        repeat (n) begin
            @(posedge aclk);
            count_in <= 1'b1;
            repeat (2) @(posedge aclk);
            count_in <= 1'b0;
            repeat (2) @(posedge aclk);
        end
    endtask

    // One capture pulse; the rise and the fall are used apart
    task automatic pulse_cap(input int width);
        @(posedge aclk);
        cap_in <= 1'b1;
        repeat (width) @(posedge aclk);
        cap_in <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask
endmodule

/* File: test_match_capture_counter_timer.sv */
// Self-checking bench for the counter-timer, 32-bit build.
// Assumes the defines header and package are compiled first.
`include "mct_defines.svh"
module test_match_capture_counter_timer;
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------------
    // Signals and counters
    // ------------------------------------------------------------------
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [3:0]  wstrb = 4'hf, match_out;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic        cap_in, count_in;
    logic [1:0]  bresp, rresp, rs;
    int          bad_count = 0, n_compared = 0, cycles = 0;

    typedef struct {
        logic [7:0]  addr;
        logic [31:0] wd;
        logic [31:0] exp;
    } row_type;
    row_type rows [7] = '{
        '{`MCT_ADDR_PRE_LIM, 32'hffff_ffff, 32'hffff_ffff},
        '{`MCT_ADDR_COUNT,   32'h0000_0007, 32'h0000_0007},
        '{`MCT_ADDR_MATCH0,  32'h1234_5678, 32'h1234_5678},
        '{`MCT_ADDR_MASK,    32'h0000_00ff, 32'h0000_001f},
        '{`MCT_ADDR_EXTOUT,  32'h0000_ffff, 32'h0000_00ff},
        '{`MCT_ADDR_CAPCTL,  32'h0000_000f, 32'h0000_000f},
        '{`MCT_ADDR_MCTL,    32'h0000_ffff, 32'h0000_0fff}};

    always #50 aclk = ~aclk;

    mct_timer #(.WIDTH(32)) DUT (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .cap_in(cap_in), .count_in(count_in),
        .match_out(match_out), .irq(irq));

    mct_far_side far (.aclk(aclk), .cap_in(cap_in), .count_in(count_in));

    // ------------------------------------------------------------------
    // Bus tasks and comparison
    // ------------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic got_b;
        got_b = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!got_b) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                got_b = 1'b1;
                rs = bresp;
                bready <= 1'b0;
            end
        end
    endtask

    task automatic rdr(input logic [7:0] a);
        logic got_r;
        got_r = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!got_r) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                got_r = 1'b1;
                rd = rdata;
                rs = rresp;
                rready <= 1'b0;
            end
        end
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
            bad_count++;
        end
    endtask

    // Polls the enable bit; a stop on match clears it
    task automatic wait_stop();
        for (int i = 0; i < 60; i++) begin
            rdr(`MCT_ADDR_CTRL);
            if (rd[0] === 1'b0) break;
        end
    endtask

    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Hang guard: the whole sequence needs a few hundred cycles
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            end_sim();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        check({31'h0, irq}, 32'h0);
        check({28'h0, match_out}, 32'h0);
        rdr(`MCT_ADDR_CTRL);
        check(rd, `MCT_CTRL_RST);
        rdr(8'h28);
        check({rd[31:2], rs}, {30'h0, `MCT_RESP_SLVERR});
        wr(8'h2c, 32'h1);
        check({30'h0, rs}, {30'h0, `MCT_RESP_SLVERR});
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wd);
            rdr(rows[i].addr);
            check(rd, rows[i].exp);
        end
        $display("test registers done");
        // Huge limit: no advance in 40 cycles, prescale count moves
        wr(`MCT_ADDR_MCTL, 32'h0);
        wr(`MCT_ADDR_COUNT, 32'h0);
        wr(`MCT_ADDR_PRE_CNT, 32'h0);
        wr(`MCT_ADDR_CTRL, 32'h1);
        repeat (40) @(posedge aclk);
        rdr(`MCT_ADDR_COUNT);
        check(rd, 32'h0);
        rdr(`MCT_ADDR_PRE_CNT);
        check({31'h0, rd >= 40 && rd < 80}, 32'h1);
        // Divide by two, stop and flag on match 0
        wr(`MCT_ADDR_CTRL, 32'h0);
        wr(`MCT_ADDR_PRE_LIM, 32'h1);
        wr(`MCT_ADDR_PRE_CNT, 32'h0); // Above the limit it would not wrap
        wr(`MCT_ADDR_COUNT, 32'h0);
        wr(`MCT_ADDR_MATCH0, 32'h5);
        wr(`MCT_ADDR_MCTL, 32'h5);
        wr(`MCT_ADDR_MASK, 32'h1);
        wr(`MCT_ADDR_STATUS, 32'h1f);
        wr(`MCT_ADDR_CTRL, 32'h1);
        wait_stop();
        check(rd, 32'h0);
        rdr(`MCT_ADDR_COUNT);
        check(rd, 32'h5);
        rdr(`MCT_ADDR_STATUS);
        check({31'h0, rd[0]}, 32'h1);
        check({31'h0, irq}, 32'h1);
        $display("test prescale and stop done");
        // Reset on match 1 while running; mask then clear the flag
        wr(`MCT_ADDR_PRE_LIM, 32'h0);
        wr(`MCT_ADDR_MATCH1, 32'h3);
        wr(`MCT_ADDR_MCTL, 32'h30);
        wr(`MCT_ADDR_MASK, 32'h2);
        wr(`MCT_ADDR_STATUS, 32'h1f);
        wr(`MCT_ADDR_COUNT, 32'h0);
        wr(`MCT_ADDR_CTRL, 32'h1);
        repeat (4) begin
            rdr(`MCT_ADDR_COUNT);
            check({31'h0, rd <= 3}, 32'h1);
        end
        rdr(`MCT_ADDR_CTRL);
        check({31'h0, rd[0]}, 32'h1);
        check({31'h0, irq}, 32'h1);
        wr(`MCT_ADDR_MASK, 32'h0);
        repeat (3) @(posedge aclk);
        check({31'h0, irq}, 32'h0);
        wr(`MCT_ADDR_CTRL, 32'h0);
        wr(`MCT_ADDR_STATUS, 32'h1f);
        rdr(`MCT_ADDR_STATUS);
        check(rd, 32'h0);
        $display("test reset on match done");
        // All four matches at 2; pins all high, then low/hold/toggle
        for (int i = 0; i < 4; i++) wr(`MCT_ADDR_MATCH0 + 8'(4 * i), 32'h2);
        wr(`MCT_ADDR_MCTL, 32'h1);
        for (int k = 0; k < 2; k++) begin
            wr(`MCT_ADDR_COUNT, 32'h0);
            wr(`MCT_ADDR_EXTOUT, (k == 0) ?
                {24'h0, mct_pkg::EXT_HIGH, mct_pkg::EXT_HIGH,
                 mct_pkg::EXT_HIGH, mct_pkg::EXT_HIGH} :
                {24'h0, mct_pkg::EXT_LOW, mct_pkg::EXT_HOLD,
                 mct_pkg::EXT_TOGGLE, mct_pkg::EXT_LOW});
            wr(`MCT_ADDR_CTRL, 32'h1);
            wait_stop();
            check({28'h0, match_out}, (k == 0) ? 32'hf : 32'h4);
        end
        $display("test match pins done");
        // External edges counted, rising then falling
        wr(`MCT_ADDR_MCTL, 32'h0);
        wr(`MCT_ADDR_COUNT, 32'h0);
        wr(`MCT_ADDR_CTRL, 32'h3);
        far.pulse_count(5);
        rdr(`MCT_ADDR_COUNT);
        check(rd, 32'h5);
        wr(`MCT_ADDR_CTRL, 32'h7);
        far.pulse_count(5);
        rdr(`MCT_ADDR_COUNT);
        check(rd, 32'ha);
        $display("test counter mode done");
        // Pulse width: rise clears, fall captures and interrupts
        wr(`MCT_ADDR_CAPCTL, 32'h6);
        wr(`MCT_ADDR_MASK, 32'h10);
        wr(`MCT_ADDR_STATUS, 32'h1f);
        wr(`MCT_ADDR_COUNT, 32'h00ab_0000);
        wr(`MCT_ADDR_CTRL, 32'h1);
        far.pulse_cap(20);
        rdr(`MCT_ADDR_CAPVAL);
        check({31'h0, rd >= 18 && rd <= 21}, 32'h1);
        rdr(`MCT_ADDR_STATUS);
        check({31'h0, rd[`MCT_STAT_CAP]}, 32'h1);
        check({31'h0, irq}, 32'h1);
        $display("test capture done");
        // Reset in mid-run: pins, irq and settings return to idle
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        check({31'h0, irq}, 32'h0);
        check({28'h0, match_out}, 32'h0);
        rdr(`MCT_ADDR_CAPCTL);
        check(rd, 32'h0);
        $display("test mid-run reset done");
        end_sim();
    end
endmodule
